// File: sweep_pkg.sv
// Purpose: Constants for the sweep control register bank
// Assumes: Byte-wide register port, one clock domain
// Notes: Byte addresses are the printed register addresses
`default_nettype none
package sweep_pkg;
    localparam logic [7:0] ADDR_CTRL_HI = 8'h80;
    localparam logic [7:0] ADDR_CTRL_LO = 8'h81;
    localparam logic [7:0] ADDR_START = 8'h82;
    localparam logic [7:0] ADDR_STEP = 8'h85;
    localparam logic [7:0] ADDR_COUNT = 8'h88;
    localparam logic [7:0] ADDR_SETTLE = 8'h8a;
    localparam logic [7:0] ADDR_STATUS = 8'h8f;
    localparam logic [7:0] ADDR_REAL = 8'h94;
    localparam logic [7:0] ADDR_IMAG = 8'h96;
    localparam logic [15:0] CTRL_RESET = 16'ha000;
    // Field positions inside the high and low control bytes and the status byte
    localparam int HI_CMD_LSB = 4;
    localparam int HI_RANGE_LSB = 1;
    localparam int HI_GAIN_BIT = 0;
    localparam int LO_RESET_BIT = 4;
    localparam int LO_EXTCLK_BIT = 3;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam logic [3:0] CMD_INIT = 4'h1;
    localparam logic [3:0] CMD_START = 4'h2;
    localparam logic [3:0] CMD_INC = 4'h3;
    localparam logic [3:0] CMD_REPEAT = 4'h4;
    localparam logic [3:0] CMD_PDOWN = 4'ha;
    localparam logic [3:0] CMD_STBY = 4'hb;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HOLD = 3'b001,
        ST_SETTLE = 3'b010,
        ST_CONV = 3'b011,
        ST_WAIT = 3'b100
    } sweep_state_t;
endpackage
`default_nettype wire

// File: sweep_control_register_bank.sv
// Purpose: Control word, sweep registers and sweep sequencer
// Assumes: Byte accesses come from serial bus logic on clk_sys_i
// Notes: Result and status bytes are read only
// Functional notes
// R1: 16-bit control word, resets to 0xA000
// R2: Top nibble decodes sweep and power commands
// R3: High byte write leaves low byte alone
// R4: Host never block-writes the control word
// R5: Reset bit aborts sweep, keeps sweep setup
// R6: Host re-initializes after a reset
// R7: Bits 10:9 select excitation range
// R8: Bit 8 sets gain; bit 11 ignored
// R9: Bit 3 selects external system clock
// R10: 16-bit settling count over two bytes
// R11: Host adds 180 degrees when both negative
// R12: Host converts radians to degrees
// R13: Host subtracts calibrated system phase
// R14: One calibration pair gives gain and phase
// R15: Host projects magnitude by cosine and sine
// R16: Nibble encodes init, start, step, repeat, power
// R17: Wait settling cycles before each conversion
// R18: Host zeroes reserved bits; read-only writes ignored
`timescale 1ns/1ps
`default_nettype none
module sweep_control_register_bank (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic out_cycle_i,
    input wire logic conv_done_i,
    input wire logic [15:0] res_real_i,
    input wire logic [15:0] res_imag_i,
    output logic [7:0] reg_rdata_o,
    output logic [1:0] range_sel_o,
    output logic gain_unity_o,
    output logic ext_clk_sel_o,
    output logic power_down_o,
    output logic standby_o,
    output logic conv_start_o,
    output logic [23:0] freq_word_o
);

////////////////////////////////////////////////////////////////////////

function automatic logic [23:0] put24(input logic [23:0] v,
                                      input logic [7:0] off,
                                      input logic [7:0] d);
    logic [23:0] r;
    r = v;
    case (off)
        8'h00: r[23:16] = d;
        8'h01: r[15:8] = d;
        default: r[7:0] = d;
    endcase
    return r;
endfunction

function automatic logic [15:0] put16(input logic [15:0] v,
                                      input logic [7:0] off,
                                      input logic [7:0] d);
    logic [15:0] r;
    r = v;
    if (off == 8'h00)
    begin
        r[15:8] = d;
    end
    else
    begin
        r[7:0] = d;
    end
    return r;
endfunction

function automatic logic in_rng(input logic [7:0] a,
                                input logic [7:0] base,
                                input logic [7:0] n);
    return (a >= base) && (a < base + n);
endfunction

////////////////////////////////////////////////////////////////////////

logic rst_q1_r;
logic rst_r;
always_ff @(posedge clk_sys_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        rst_q1_r <= 1'b0;
        rst_r <= 1'b0;
    end
    else
    begin
        rst_q1_r <= 1'b1;
        rst_r <= rst_q1_r;
    end
end

logic [7:0] ctrl_hi_r;
logic [7:0] ctrl_lo_r;
logic [23:0] start_r;
logic [23:0] step_r;
logic [15:0] count_r;
logic [15:0] settle_r;
logic [15:0] real_r;
logic [15:0] imag_r;
sweep_pkg::sweep_state_t state_r;
sweep_pkg::sweep_state_t state_nxt;
logic [15:0] point_r;
logic [15:0] point_nxt;
logic [15:0] settle_cnt_r;
logic [15:0] cnt_nxt;
logic [23:0] freq_nxt;
logic valid_r;
logic valid_nxt;
logic done_r;
logic done_nxt;
logic conv_nxt;
logic pd_nxt;
logic sb_nxt;

wire logic wr_ctrl_hi = reg_wr_i && (reg_addr_i == sweep_pkg::ADDR_CTRL_HI);
wire logic wr_ctrl_lo = reg_wr_i && (reg_addr_i == sweep_pkg::ADDR_CTRL_LO);
wire logic wr_start = reg_wr_i && in_rng(reg_addr_i, sweep_pkg::ADDR_START, 8'h03);
wire logic wr_step = reg_wr_i && in_rng(reg_addr_i, sweep_pkg::ADDR_STEP, 8'h03);
wire logic wr_count = reg_wr_i && in_rng(reg_addr_i, sweep_pkg::ADDR_COUNT, 8'h02);
wire logic wr_settle = reg_wr_i && in_rng(reg_addr_i, sweep_pkg::ADDR_SETTLE, 8'h02);
wire logic [3:0] cmd = reg_wdata_i[sweep_pkg::HI_CMD_LSB +: 4];
// Reset bit acts as a strobe and is never stored
wire logic abort = wr_ctrl_lo && reg_wdata_i[sweep_pkg::LO_RESET_BIT];
wire logic capture = (state_r == sweep_pkg::ST_CONV) && conv_done_i;
wire logic [7:0] status = {5'h00, done_r, valid_r, 1'b0};

////////////////////////////////////////////////////////////////////////
// Register file

always_ff @(posedge clk_sys_i or negedge rst_r)
begin
    if (!rst_r)
    begin
        ctrl_hi_r <= sweep_pkg::CTRL_RESET[15:8]; // R1
        ctrl_lo_r <= sweep_pkg::CTRL_RESET[7:0]; // R1
        start_r <= 24'h000000;
        step_r <= 24'h000000;
        count_r <= 16'h0000;
        settle_r <= 16'h0000;
    end
    else
    begin
        // Each control byte has its own strobe, so one never disturbs the other
        if (wr_ctrl_hi)
            ctrl_hi_r <= reg_wdata_i; // R3
        if (wr_ctrl_lo)
            ctrl_lo_r <= reg_wdata_i & ~(8'h01 << sweep_pkg::LO_RESET_BIT);
        if (wr_start)
            start_r <= put24(start_r, reg_addr_i - sweep_pkg::ADDR_START, reg_wdata_i);
        if (wr_step)
            step_r <= put24(step_r, reg_addr_i - sweep_pkg::ADDR_STEP, reg_wdata_i);
        if (wr_count)
            count_r <= put16(count_r, reg_addr_i - sweep_pkg::ADDR_COUNT, reg_wdata_i);
        if (wr_settle)
            settle_r <= put16(settle_r, reg_addr_i - sweep_pkg::ADDR_SETTLE, reg_wdata_i); // R10
    end
end

// Bit 11 of the word is stored for readback but drives nothing
assign range_sel_o = ctrl_hi_r[sweep_pkg::HI_RANGE_LSB +: 2]; // R7
assign gain_unity_o = ctrl_hi_r[sweep_pkg::HI_GAIN_BIT]; // R8
assign ext_clk_sel_o = ctrl_lo_r[sweep_pkg::LO_EXTCLK_BIT]; // R9

////////////////////////////////////////////////////////////////////////
// Sweep sequencer

always_comb
begin
    state_nxt = state_r;
    freq_nxt = freq_word_o;
    point_nxt = point_r;
    cnt_nxt = settle_cnt_r;
    valid_nxt = valid_r;
    done_nxt = done_r;
    conv_nxt = 1'b0;
    pd_nxt = power_down_o;
    sb_nxt = standby_o;
    case (state_r)
        sweep_pkg::ST_SETTLE:
        begin
            if (settle_cnt_r >= settle_r) // R17
            begin
                state_nxt = sweep_pkg::ST_CONV;
                conv_nxt = 1'b1;
            end
            else if (out_cycle_i)
            begin
                cnt_nxt = settle_cnt_r + 16'h0001;
            end
        end
        sweep_pkg::ST_CONV:
        begin
            if (conv_done_i)
                state_nxt = sweep_pkg::ST_WAIT;
        end
        default:
        begin
        end
    endcase
    // Abort leaves start, step and count registers untouched
    if (abort)
    begin
        state_nxt = sweep_pkg::ST_IDLE; // R5
        conv_nxt = 1'b0;
    end
    else if (wr_ctrl_hi)
    begin
        case (cmd) // R2
            sweep_pkg::CMD_INIT:
            begin
                state_nxt = sweep_pkg::ST_HOLD; // R16
                freq_nxt = start_r;
                point_nxt = 16'h0000;
                valid_nxt = 1'b0;
                done_nxt = 1'b0;
                pd_nxt = 1'b0;
                sb_nxt = 1'b0;
            end
            sweep_pkg::CMD_START:
            begin
                if (state_r == sweep_pkg::ST_HOLD)
                begin
                    state_nxt = sweep_pkg::ST_SETTLE; // R16
                    cnt_nxt = 16'h0000;
                end
            end
            sweep_pkg::CMD_INC:
            begin
                if ((state_r == sweep_pkg::ST_WAIT) && !done_r)
                begin
                    state_nxt = sweep_pkg::ST_SETTLE; // R16
                    freq_nxt = freq_word_o + step_r;
                    point_nxt = point_r + 16'h0001;
                    cnt_nxt = 16'h0000;
                    valid_nxt = 1'b0;
                end
            end
            sweep_pkg::CMD_REPEAT:
            begin
                if (state_r == sweep_pkg::ST_WAIT)
                begin
                    state_nxt = sweep_pkg::ST_SETTLE; // R16
                    cnt_nxt = 16'h0000;
                    valid_nxt = 1'b0;
                end
            end
            sweep_pkg::CMD_PDOWN:
            begin
                state_nxt = sweep_pkg::ST_IDLE; // R16
                pd_nxt = 1'b1;
                sb_nxt = 1'b0;
            end
            sweep_pkg::CMD_STBY:
            begin
                state_nxt = sweep_pkg::ST_IDLE; // R16
                pd_nxt = 1'b0;
                sb_nxt = 1'b1;
            end
            default:
            begin
            end
        endcase
    end
    // A result landing with a clearing command still raises its flags
    if (capture)
    begin
        valid_nxt = 1'b1;
        done_nxt = point_r >= count_r;
    end
end

always_ff @(posedge clk_sys_i or negedge rst_r)
begin
    if (!rst_r)
    begin
        state_r <= sweep_pkg::ST_IDLE;
        freq_word_o <= 24'h000000;
        point_r <= 16'h0000;
        settle_cnt_r <= 16'h0000;
        valid_r <= 1'b0;
        done_r <= 1'b0;
        conv_start_o <= 1'b0;
        power_down_o <= 1'b1;
        standby_o <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        freq_word_o <= freq_nxt;
        point_r <= point_nxt;
        settle_cnt_r <= cnt_nxt;
        valid_r <= valid_nxt;
        done_r <= done_nxt;
        conv_start_o <= conv_nxt;
        power_down_o <= pd_nxt;
        standby_o <= sb_nxt;
    end
end

// Results are written only by the converter; bus writes cannot reach them
always_ff @(posedge clk_sys_i or negedge rst_r)
begin
    if (!rst_r)
    begin
        real_r <= 16'h0000;
        imag_r <= 16'h0000;
    end
    else if (capture)
    begin
        real_r <= res_real_i;
        imag_r <= res_imag_i;
    end
end

////////////////////////////////////////////////////////////////////////
// Read path

function automatic logic [7:0] rd_sel(input logic [7:0] a, input logic [7:0] hi,
                                      input logic [7:0] lo, input logic [7:0] st,
                                      input logic [23:0] s, input logic [23:0] p,
                                      input logic [15:0] c, input logic [15:0] w,
                                      input logic [15:0] re, input logic [15:0] im);
    case (a)
        8'h80: return hi;
        8'h81: return lo;
        8'h82: return s[23:16];
        8'h83: return s[15:8];
        8'h84: return s[7:0];
        8'h85: return p[23:16];
        8'h86: return p[15:8];
        8'h87: return p[7:0];
        8'h88: return c[15:8];
        8'h89: return c[7:0];
        8'h8a: return w[15:8];
        8'h8b: return w[7:0];
        8'h8f: return st;
        8'h94: return re[15:8];
        8'h95: return re[7:0];
        8'h96: return im[15:8];
        8'h97: return im[7:0];
        default: return 8'h00;
    endcase
endfunction

wire logic [7:0] rd_mux = rd_sel(reg_addr_i, ctrl_hi_r, ctrl_lo_r, status, start_r,
                                 step_r, count_r, settle_r, real_r, imag_r);

always_ff @(posedge clk_sys_i or negedge rst_r)
begin
    if (!rst_r)
        reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
        reg_rdata_o <= rd_mux;
end

////////////////////////////////////////////////////////////////////////
// Checks

ctrl_reset_a: assert property (@(posedge clk_sys_i) $rose(rst_r) |-> // R1
    {ctrl_hi_r, ctrl_lo_r} == sweep_pkg::CTRL_RESET && power_down_o)
    else $error("control word not at reset value");
hi_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R3
    wr_ctrl_hi |=> ctrl_lo_r == $past(ctrl_lo_r))
    else $error("high byte write changed low byte");
abort_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R5
    abort |=> state_r == sweep_pkg::ST_IDLE && !conv_start_o
    && start_r == $past(start_r) && step_r == $past(step_r) && count_r == $past(count_r))
    else $error("abort did not stop sweep cleanly");
init_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R16
    wr_ctrl_hi && cmd == sweep_pkg::CMD_INIT && !abort
    |=> freq_word_o == $past(start_r) && state_r == sweep_pkg::ST_HOLD)
    else $error("init did not load start frequency");
range_gain_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R7
    wr_ctrl_hi |=> range_sel_o == $past(reg_wdata_i[2:1])
    && gain_unity_o == $past(reg_wdata_i[0]))
    else $error("range or gain not taken from control word");
clock_src_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R9
    wr_ctrl_lo |=> ext_clk_sel_o == $past(reg_wdata_i[3]))
    else $error("clock source bit not applied");
settle_wait_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R17
    conv_start_o |-> $past(state_r) == sweep_pkg::ST_SETTLE
    && $past(settle_cnt_r) >= $past(settle_r))
    else $error("conversion started before settling");
settle_reg_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R10
    reg_wr_i && reg_addr_i == sweep_pkg::ADDR_SETTLE |=> settle_r[15:8] == $past(reg_wdata_i))
    else $error("settling high byte not written");
pdown_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!rst_r) // R2
    wr_ctrl_hi && cmd == sweep_pkg::CMD_PDOWN && !abort
    |=> power_down_o && !standby_o && state_r == sweep_pkg::ST_IDLE)
    else $error("power-down command not applied");

endmodule
`default_nettype wire

// File: host_bus_model.sv
// Purpose: Host side of the byte-wide register bus
// Assumes: Strobes change at falling edges of clk_i, one byte per strobe
// Notes: Lines not qualified by a strobe show inverted junk, never stale data
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Control word goes as single byte writes only, never as a burst
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = (a == 8'h81) ? (d & 8'h18) : d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~addr_o;
        d = rdata_i;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Host post-processing of result pairs, angles in degrees
    function automatic real std_phase(input logic [15:0] re, input logic [15:0] im);
        real r;
        real i;
        real ph;
        r = real'($signed(re));
        i = real'($signed(im));
        ph = (r == 0.0) ? 90.0 : $atan(i / r) * 180.0 / 3.14159265358979;
        if (r < 0.0 && i < 0.0)
            ph = ph + 180.0;
        return ph;
    endfunction
    function automatic real magnitude(input logic [15:0] re, input logic [15:0] im);
        real r;
        real i;
        r = real'($signed(re));
        i = real'($signed(im));
        return $sqrt(r * r + i * i);
    endfunction
    // Resistive part by cosine, reactive part by sine of the impedance phase
    function automatic real axis_part(input real mag, input real ph_deg, input bit imag_part);
        real rad;
        rad = ph_deg * 3.14159265358979 / 180.0;
        return imag_part ? mag * $sin(rad) : mag * $cos(rad);
    endfunction
endmodule
`default_nettype wire

// File: sweep_control_register_bank_tb.sv
// Purpose: Self-checking bench for the sweep control register bank
// Assumes: Inputs change at falling edges; results come from a bench stub
// Notes: Expected bytes live in an integer map updated on every write to a writable byte
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module sweep_control_register_bank_tb;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr, wdata, rdata, rd_val;
    logic wr, rd, gain_unity, ext_clk, pd, sb, conv_start;
    logic out_cycle = 1'b0;
    logic conv_done = 1'b0;
    logic [15:0] res_re = 16'h0000;
    logic [15:0] res_im = 16'h0000;
    logic [1:0] range_sel;
    logic [23:0] freq;
    int n_errors = 0;
    int total_checks = 0;
    int n_starts = 0;
    int exp_mem [256];
    // Calibration resistor value is arbitrary
    localparam real CAL_OHMS = 1000.0;
    real ph_now, mag_now, sys_ph, gain_f, z_ph, z_re, z_im;
    bit ok_ph;
    int s, p, k, base;
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (conv_start === 1'b1) n_starts++;
    host_bus_model host_u (.clk_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    sweep_control_register_bank dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .out_cycle_i(out_cycle), .conv_done_i(conv_done),
        .res_real_i(res_re), .res_imag_i(res_im), .reg_rdata_o(rdata), .range_sel_o(range_sel),
        .gain_unity_o(gain_unity), .ext_clk_sel_o(ext_clk), .power_down_o(pd), .standby_o(sb),
        .conv_start_o(conv_start), .freq_word_o(freq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Only writable bytes enter the map; the reset bit never reads back
    task automatic put(input int a, input int d);
        if (a >= 8'h80 && a <= 8'h8b) exp_mem[a] = (a == 8'h81) ? (d & 8'h08) : d;
        host_u.wr_byte(a[7:0], d[7:0]);
    endtask
    task automatic get(input int a);
        host_u.rd_byte(a[7:0], rd_val);
        `CHK("rdata", exp_mem[a], rd_val)
    endtask
    task automatic pulse;
        @(negedge clk_sys_i);
        out_cycle = 1'b1;
        @(negedge clk_sys_i);
        out_cycle = 1'b0;
    endtask
    // Settling count is 2: no start after one output cycle, one start after two
    task automatic measure(input int pt);
        base = n_starts;
        pulse();
        repeat (3) @(negedge clk_sys_i);
        `CHK("early start", base, n_starts)
        pulse();
        repeat (3) @(negedge clk_sys_i);
        `CHK("start count", base + 1, n_starts)
        res_re = 16'($urandom);
        res_im = 16'($urandom);
        conv_done = 1'b1;
        @(negedge clk_sys_i);
        conv_done = 1'b0;
        exp_mem[8'h8f] = 2 | ((pt >= 1) ? 4 : 0);
        exp_mem[8'h94] = res_re[15:8];
        exp_mem[8'h95] = res_re[7:0];
        exp_mem[8'h96] = res_im[15:8];
        exp_mem[8'h97] = res_im[7:0];
        for (k = 8'h94; k <= 8'h97; k++) get(k);
        get(8'h8f);
        ph_now = host_u.std_phase(res_re, res_im);
        mag_now = host_u.magnitude(res_re, res_im);
        // Third quadrant gets the half-turn offset, a positive pair none
        if (res_re[15] && res_im[15])
            ok_ph = (ph_now > 180.0) && (ph_now < 270.0);
        else if (!res_re[15] && !res_im[15])
            ok_ph = (ph_now >= 0.0) && (ph_now <= 90.0);
        else
            ok_ph = (ph_now >= -90.0) && (ph_now <= 90.0);
        `CHK("phase", 1'b1, ok_ph)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h33138f3b));
        for (k = 8'h80; k <= 8'h97; k++) exp_mem[k] = 0;
        exp_mem[8'h80] = 8'ha0;
        repeat (5) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        get(8'h80);
        get(8'h81);
        `CHK("pd", 1'b1, pd)
        $display("test reset done");
        put(8'h81, 8'h08);
        `CHK("extclk", 1'b1, ext_clk)
        put(8'h81, 8'h00);
        `CHK("extclk", 1'b0, ext_clk)
        put(8'h81, 8'h08);
        for (k = 0; k < 16; k++)
        begin
            put(8'h80, k);
            `CHK("range", k[2:1], range_sel)
            `CHK("gain", k[0], gain_unity)
            get(8'h81);
        end
        $display("test control fields done");
        for (k = 8'h82; k <= 8'h89; k++) put(k, $urandom & 8'hff);
        put(8'h8a, 8'h00);
        put(8'h8b, 8'h02);
        put(8'h88, 8'h00);
        put(8'h89, 8'h01);
        put(8'h8f, 8'hff);
        put(8'h94, 8'h5a);
        for (k = 8'h82; k <= 8'h97; k++) get(k);
        s = (exp_mem[8'h82] << 16) | (exp_mem[8'h83] << 8) | exp_mem[8'h84];
        p = (exp_mem[8'h85] << 16) | (exp_mem[8'h86] << 8) | exp_mem[8'h87];
        $display("test registers done");
        put(8'h80, 8'h10);
        `CHK("freq", s, freq)
        `CHK("pd", 1'b0, pd)
        `CHK("sb", 1'b0, sb)
        put(8'h80, 8'h20);
        measure(0);
        // First point stands in for the calibration resistor measurement
        sys_ph = ph_now;
        gain_f = 1.0 / (CAL_OHMS * mag_now);
        put(8'h80, 8'h40);
        measure(0);
        `CHK("freq", s, freq)
        put(8'h80, 8'h30);
        `CHK("freq", (s + p) & 24'hffffff, freq)
        measure(1);
        z_ph = ph_now - sys_ph;
        z_re = host_u.axis_part(1.0 / (gain_f * mag_now), z_ph, 1'b0);
        z_im = host_u.axis_part(1.0 / (gain_f * mag_now), z_ph, 1'b1);
        put(8'h80, 8'h30);
        `CHK("freq", (s + p) & 24'hffffff, freq)
        $display("test sweep done phase %0f re %0f im %0f", z_ph, z_re, z_im);
        put(8'h80, 8'h10);
        put(8'h80, 8'h20);
        base = n_starts;
        put(8'h81, 8'h18);
        repeat (3) pulse();
        repeat (3) @(negedge clk_sys_i);
        `CHK("abort", base, n_starts)
        for (k = 8'h81; k <= 8'h8b; k++) get(k);
        // A reset leaves the sequencer idle until the host initializes again
        put(8'h80, 8'h10);
        put(8'h80, 8'h20);
        measure(0);
        $display("test abort done");
        put(8'h80, 8'hb0);
        `CHK("sb", 1'b1, sb)
        `CHK("pd", 1'b0, pd)
        put(8'h80, 8'h50);
        `CHK("sb", 1'b1, sb)
        put(8'h80, 8'ha0);
        `CHK("pd", 1'b1, pd)
        `CHK("sb", 1'b0, sb)
        $display("test power done");
        stop_test();
    end
    // Whole run takes well under 2000 cycles; this cuts a hang short
    initial
    begin
        #400000;
        n_errors++;
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire
